// >>> shared/ebw_defines.svh
// Purpose: Offsets, field positions, reset values and counts
// Assumes: 32-bit register bus, one aligned word per register
// Notes:   Included by the design and the bench
`ifndef EBW_DEFINES_SVH
`define EBW_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define EBW_OFS_WAIT0     8'h00
`define EBW_OFS_CTRL      8'h20
`define EBW_OFS_ADDR      8'h24
`define EBW_OFS_WDATA     8'h28
`define EBW_OFS_CMD       8'h2C
`define EBW_OFS_STATUS    8'h30
`define EBW_OFS_RDATA     8'h34

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define EBW_CTRL_WIDTH    9
`define EBW_CMD_WIDTH     8
`define EBW_CTRL_RESET    9'h000
`define EBW_CMD_RESET     8'h00
`define EBW_WAIT_RESET    2'h0
`define EBW_MODE_SINGLE   2'h0
`define EBW_FULL_MUX_BIT  8

// ****************************************************************
// Bus cycle lengths in bus-clock periods
// ****************************************************************
`define EBW_SFR_PERIODS   3'h2
`define EBW_MUX_PERIODS   3'h3
`define EBW_ONE_PERIOD    3'h1

`endif

// >>> shared/ebw_pkg.sv
// Purpose: Types of the external bus wait and hold block
// Assumes: Constants come from ebw_defines.svh
// Notes:   Command and control words are packed structs
package ebw_pkg;

    // ****************************************************************
    // Access kinds and states
    // ****************************************************************
    typedef enum logic [1:0] {
        EBW_KIND_EXT = 2'h0,
        EBW_KIND_INT = 2'h1,
        EBW_KIND_SFR = 2'h2
    } ebw_kind_t;

    typedef enum logic [4:0] {
        EBW_ST_IDLE   = 5'h01,
        EBW_ST_CYCLE  = 5'h02,
        EBW_ST_FLOAT  = 5'h04,
        EBW_ST_GRANT  = 5'h08,
        EBW_ST_RESUME = 5'h10
    } ebw_state_t;

    // ****************************************************************
    // Register words
    // ****************************************************************
    typedef struct packed {
        logic [2:0] waitSel;
        logic       write;
        logic [1:0] area;
        ebw_kind_t  kind;
    } ebw_cmd_t;

    typedef struct packed {
        logic       fullMux;
        logic       narrow8;
        logic [3:0] muxMask;
        logic [1:0] procMode;
        logic       internalMemWaitBit;
    } ebw_ctrl_t;

endpackage : ebw_pkg

// >>> logic/ebw_bus_ctrl.sv
// Purpose: Wait states, ready stretching and bus hold for expansion bus
// Assumes: AHB-Lite register access, bus clock is clk divided by two
// Notes:   Pins split into value, input and output enable
//
// Contract
// - Separate bus external cycle: one to four periods
// - Multiplexed area: three periods for zero/one wait
// - Internal wait bit applies waits internally
// - Special function area always two periods
// - Wait count from eight wait registers
// - Ready stretching only with software wait set
// - Ready low at falling edge freezes bus
// - Frozen until falling edge samples ready high
// - Hold honoured only outside single-chip mode
// - Buses float at a falling bus-clock edge
// - Grant goes low at following rising edge
// - Grant goes high at next rising edge
// - Buses restored at next falling edge
// - Buses float whole time grant low
// - Never release bus mid-cycle
// - Address floats except upper bits as ports
// - Data floats except lines used as ports
// - Strobes and selects float, latch enable low
// - Separate read lasts wait count plus one
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "ebw_defines.svh"

module ebw_bus_ctrl
    import ebw_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             busClk,
    output logic [23:0]      busAddr,
    output logic [23:0]      busAddrOe,
    output logic [15:0]      busDataOut,
    output logic [15:0]      busDataOe,
    input  wire logic [15:0] busDataIn,
    output logic             readStrobeN,
    output logic             writeStrobeN,
    output logic             lowByteWriteN,
    output logic             highByteWriteN,
    output logic             upperByteEnableN,
    output logic [3:0]       areaSelectN,
    output logic             ctrlOe,
    output logic             addrLatchEnable,
    input  wire logic        busReadyN,
    input  wire logic        busRequestN,
    output logic             busReleaseGrantN
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [1:0]  waitCountRegs [8];
    ebw_ctrl_t   ctrl_q;
    ebw_cmd_t    cmd_q;
    ebw_cmd_t    cur_q;
    logic [23:0] addrReg_q;
    logic [15:0] wdataReg_q;
    logic [15:0] rdataReg_q;
    logic        pending_q;
    logic        wrPend_q;
    logic [7:0]  wrAddr_q;
    ebw_state_t  state_q;
    logic [2:0]  left_q;
    logic [1:0]  curWait_q;
    logic        readySync1_q;
    logic        readySync2_q;
    logic        reqSync1_q;
    logic        reqSync2_q;
    logic [15:0] dataSync1_q;
    logic [15:0] dataSync2_q;
    logic        fall;
    logic        rise;
    logic        holdAllowed;
    logic        holdTake;
    logic        startNow;
    logic        stall;
    logic        curMux;
    logic [1:0]  selWait;
    logic        accept;

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic [2:0] ebwCycleLen(
        input ebw_kind_t  kind,
        input logic       mux,
        input logic       memWait,
        input logic [1:0] w
    );
        logic [2:0] plusWait;
        plusWait = {1'b0, w} + `EBW_ONE_PERIOD;
        case (kind)
            EBW_KIND_SFR: ebwCycleLen = `EBW_SFR_PERIODS;
            EBW_KIND_INT: ebwCycleLen = memWait ? plusWait
                                                : `EBW_ONE_PERIOD;
            default:
            begin
                if (mux && w < 2'h2)
                    ebwCycleLen = `EBW_MUX_PERIODS;
                else
                    ebwCycleLen = plusWait;
            end
        endcase
    endfunction : ebwCycleLen

    function automatic logic [31:0] ebwRegRead(
        input logic [7:0] ofs,
        input ebw_ctrl_t  c,
        input ebw_cmd_t   k,
        input logic [1:0] w,
        input logic [23:0] a,
        input logic [15:0] wd,
        input logic [15:0] rd,
        input logic [4:0] st
    );
        ebwRegRead = 32'h00000000;
        if (ofs < `EBW_OFS_CTRL)
            ebwRegRead = {30'h00000000, w};
        else
        begin
            case (ofs)
                `EBW_OFS_CTRL:   ebwRegRead = {23'h000000, c};
                `EBW_OFS_ADDR:   ebwRegRead = {8'h00, a};
                `EBW_OFS_WDATA:  ebwRegRead = {16'h0000, wd};
                `EBW_OFS_CMD:    ebwRegRead = {24'h000000, k};
                `EBW_OFS_STATUS: ebwRegRead = {27'h0000000, st};
                `EBW_OFS_RDATA:  ebwRegRead = {16'h0000, rd};
                default:         ebwRegRead = 32'h00000000;
            endcase
        end
    endfunction : ebwRegRead

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            readySync1_q <= 1'b1;
            readySync2_q <= 1'b1;
            reqSync1_q   <= 1'b1;
            reqSync2_q   <= 1'b1;
            dataSync1_q  <= 16'h0000;
            dataSync2_q  <= 16'h0000;
        end
        else
        begin
            readySync1_q <= busReadyN;
            readySync2_q <= readySync1_q;
            reqSync1_q   <= busRequestN;
            reqSync2_q   <= reqSync1_q;
            dataSync1_q  <= busDataIn;
            dataSync2_q  <= dataSync1_q;
        end
    end

    // ****************************************************************
    // Bus clock
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (srst)
            busClk <= 1'b0;
        else
            busClk <= ~busClk;
    end

    assign fall = busClk;
    assign rise = ~busClk;

    // ****************************************************************
    // AHB-Lite slave
    // ****************************************************************
    assign accept = hsel && hready && htrans[1];

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
            wrPend_q  <= 1'b0;
            wrAddr_q  <= 8'h00;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPend_q  <= accept && hwrite;
            wrAddr_q  <= haddr[7:0];
            if (accept && !hwrite)
                hrdata <= ebwRegRead(haddr[7:0], ctrl_q, cmd_q,
                                     waitCountRegs[haddr[4:2]],
                                     addrReg_q, wdataReg_q, rdataReg_q,
                                     {busReleaseGrantN, ~ctrlOe,
                                      state_q == EBW_ST_CYCLE,
                                      ~busReleaseGrantN, pending_q});
            else
                hrdata <= 32'h00000000;
        end
    end

    // ****************************************************************
    // Wait control registers
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : gWait
            always_ff @(posedge clk)
            begin
                if (srst)
                    waitCountRegs[gi] <= `EBW_WAIT_RESET;
                else if (wrPend_q && wrAddr_q == `EBW_OFS_WAIT0 + 8'(gi * 4))
                    waitCountRegs[gi] <= hwdata[1:0];
            end
        end
    endgenerate

    // ****************************************************************
    // Control, address and command registers
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_q     <= `EBW_CTRL_RESET;
            addrReg_q  <= 24'h000000;
            wdataReg_q <= 16'h0000;
            cmd_q      <= `EBW_CMD_RESET;
        end
        else if (wrPend_q)
        begin
            case (wrAddr_q)
                `EBW_OFS_CTRL:  ctrl_q     <= hwdata[`EBW_CTRL_WIDTH-1:0];
                `EBW_OFS_ADDR:  addrReg_q  <= hwdata[23:0];
                `EBW_OFS_WDATA: wdataReg_q <= hwdata[15:0];
                `EBW_OFS_CMD:
                begin
                    if (!pending_q)
                        cmd_q <= hwdata[`EBW_CMD_WIDTH-1:0];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            pending_q <= 1'b0;
        else if (startNow)
            pending_q <= 1'b0;
        else if (wrPend_q && wrAddr_q == `EBW_OFS_CMD)
            pending_q <= 1'b1;
    end

    // ****************************************************************
    // Cycle control
    // ****************************************************************
    assign holdAllowed = ctrl_q.procMode != `EBW_MODE_SINGLE;
    assign holdTake    = state_q == EBW_ST_IDLE && fall && !reqSync2_q
                         && holdAllowed;
    assign startNow    = state_q == EBW_ST_IDLE && fall && pending_q
                         && !holdTake;
    assign selWait     = waitCountRegs[cmd_q.waitSel];
    assign curMux      = ctrl_q.fullMux || ctrl_q.muxMask[cmd_q.area];
    assign stall       = !readySync2_q && curWait_q != 2'h0
                         && cur_q.kind == EBW_KIND_EXT;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q   <= EBW_ST_IDLE;
            left_q    <= 3'h0;
            cur_q     <= `EBW_CMD_RESET;
            curWait_q <= 2'h0;
        end
        else
        begin
            case (state_q)
                EBW_ST_IDLE:
                begin
                    if (holdTake)
                        state_q <= EBW_ST_FLOAT;
                    else if (startNow)
                    begin
                        state_q   <= EBW_ST_CYCLE;
                        cur_q     <= cmd_q;
                        curWait_q <= selWait;
                        left_q    <= ebwCycleLen(cmd_q.kind, curMux,
                                     ctrl_q.internalMemWaitBit, selWait);
                    end
                end
                EBW_ST_CYCLE:
                begin
                    if (fall && !stall)
                    begin
                        if (left_q == `EBW_ONE_PERIOD)
                            state_q <= EBW_ST_IDLE;
                        left_q <= left_q - `EBW_ONE_PERIOD;
                    end
                end
                EBW_ST_FLOAT:
                begin
                    if (rise)
                        state_q <= EBW_ST_GRANT;
                end
                EBW_ST_GRANT:
                begin
                    if (rise && reqSync2_q)
                        state_q <= EBW_ST_RESUME;
                end
                EBW_ST_RESUME:
                begin
                    if (fall)
                        state_q <= EBW_ST_IDLE;
                end
                default: state_q <= EBW_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            rdataReg_q <= 16'h0000;
        else if (state_q == EBW_ST_CYCLE && fall && !stall
                 && left_q == `EBW_ONE_PERIOD && !cur_q.write)
            rdataReg_q <= dataSync2_q;
    end

    // ****************************************************************
    // Grant output
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (srst)
            busReleaseGrantN <= 1'b1;
        else if (state_q == EBW_ST_FLOAT && rise)
            busReleaseGrantN <= 1'b0;
        else if (state_q == EBW_ST_GRANT && rise && reqSync2_q)
            busReleaseGrantN <= 1'b1;
    end

    // ****************************************************************
    // Pin drivers and enables
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            busAddr          <= 24'h000000;
            busDataOut       <= 16'h0000;
            readStrobeN      <= 1'b1;
            writeStrobeN     <= 1'b1;
            lowByteWriteN    <= 1'b1;
            highByteWriteN   <= 1'b1;
            upperByteEnableN <= 1'b1;
            areaSelectN      <= 4'hF;
            addrLatchEnable  <= 1'b0;
        end
        else
        begin
            addrLatchEnable <= 1'b0;
            if (startNow && cmd_q.kind == EBW_KIND_EXT)
            begin
                busAddr          <= addrReg_q;
                busDataOut       <= wdataReg_q;
                readStrobeN      <= cmd_q.write;
                writeStrobeN     <= ~cmd_q.write;
                lowByteWriteN    <= ~cmd_q.write;
                highByteWriteN   <= ~(cmd_q.write && !ctrl_q.narrow8);
                upperByteEnableN <= ctrl_q.narrow8;
                areaSelectN      <= ~(4'h1 << cmd_q.area);
                addrLatchEnable  <= curMux;
            end
            else if (state_q == EBW_ST_CYCLE && fall && !stall
                     && left_q == `EBW_ONE_PERIOD)
            begin
                readStrobeN      <= 1'b1;
                writeStrobeN     <= 1'b1;
                lowByteWriteN    <= 1'b1;
                highByteWriteN   <= 1'b1;
                upperByteEnableN <= 1'b1;
                areaSelectN      <= 4'hF;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrlOe    <= 1'b1;
            busAddrOe <= 24'hFFFFFF;
            busDataOe <= 16'h0000;
        end
        else if (holdTake)
        begin
            ctrlOe    <= 1'b0;
            busAddrOe <= {4'h0, {4{ctrl_q.fullMux}}, 16'h0000}
                         & busAddrOe;
            busDataOe <= {{8{ctrl_q.fullMux || ctrl_q.narrow8}},
                          {8{ctrl_q.fullMux}}} & busDataOe;
        end
        else if (state_q == EBW_ST_RESUME && fall)
        begin
            ctrlOe    <= 1'b1;
            busAddrOe <= 24'hFFFFFF;
        end
        else if (startNow)
            busDataOe <= {16{cmd_q.kind == EBW_KIND_EXT && cmd_q.write}};
        else if (state_q == EBW_ST_CYCLE && fall && !stall
                 && left_q == `EBW_ONE_PERIOD)
            busDataOe <= 16'h0000;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_sfrLen;
        @(posedge clk) disable iff (srst)
        startNow && cmd_q.kind == EBW_KIND_SFR |=> left_q == 3'h2;
    endproperty
    a_sfrLen: assert property (p_sfrLen)
        else $error("special area cycle not two periods");

    property p_intLen;
        @(posedge clk) disable iff (srst)
        startNow && cmd_q.kind == EBW_KIND_INT
        |=> left_q == ($past(ctrl_q.internalMemWaitBit)
                       ? 3'h1 + 3'(curWait_q) : 3'h1);
    endproperty
    a_intLen: assert property (p_intLen)
        else $error("internal cycle length ignores wait bit");

    property p_muxLen;
        @(posedge clk) disable iff (srst)
        startNow && cmd_q.kind == EBW_KIND_EXT && curMux
        |=> left_q >= 3'h3;
    endproperty
    a_muxLen: assert property (p_muxLen)
        else $error("multiplexed cycle shorter than three periods");

    property p_freeze;
        @(posedge clk) disable iff (srst)
        state_q == EBW_ST_CYCLE && fall && stall
        |=> left_q == $past(left_q) && $stable(areaSelectN);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("bus moved while ready low");

    property p_grantAfterFloat;
        @(posedge clk) disable iff (srst)
        $fell(ctrlOe) |=> !busReleaseGrantN;
    endproperty
    a_grantAfterFloat: assert property (p_grantAfterFloat)
        else $error("grant not low at rising edge after float");

    property p_floatWhileGrant;
        @(posedge clk) disable iff (srst)
        !busReleaseGrantN |-> !ctrlOe && !addrLatchEnable
                              && busAddrOe[15:0] == 16'h0000;
    endproperty
    a_floatWhileGrant: assert property (p_floatWhileGrant)
        else $error("pins driven while grant low");

    property p_noMidCycle;
        @(posedge clk) disable iff (srst)
        state_q == EBW_ST_CYCLE |-> ctrlOe && busReleaseGrantN;
    endproperty
    a_noMidCycle: assert property (p_noMidCycle)
        else $error("bus released during a cycle");

    property p_release;
        @(posedge clk) disable iff (srst)
        !busReleaseGrantN && rise && reqSync2_q |=> busReleaseGrantN;
    endproperty
    a_release: assert property (p_release)
        else $error("grant not raised after request ended");

    property p_restore;
        @(posedge clk) disable iff (srst)
        $rose(busReleaseGrantN) |=> ctrlOe;
    endproperty
    a_restore: assert property (p_restore)
        else $error("buses not restored at next falling edge");

    property p_singleChip;
        @(posedge clk) disable iff (srst)
        ctrl_q.procMode == `EBW_MODE_SINGLE && $stable(ctrl_q.procMode)
        && busReleaseGrantN |=> busReleaseGrantN;
    endproperty
    a_singleChip: assert property (p_singleChip)
        else $error("hold granted in single-chip mode");

endmodule : ebw_bus_ctrl

// >>> sim/ebw_far_model.sv
// Purpose: Far-side memory and other bus master
// Assumes: Pins active low, bench sets stall and hold
// Notes:   Released data lines toggle every clock
`timescale 1ns/1ns
module ebw_far_model (
    input  wire logic       clk,
    input  wire logic       readStrobeN,
    input  wire logic [3:0] stallLen,
    input  wire logic       holdReq,
    output logic [15:0]     busDataIn,
    output logic            busReadyN,
    output logic            busRequestN
);
    logic [3:0] cnt;
    initial
    begin
        cnt = 4'h0;
        busDataIn = 16'h0000;
        busReadyN = 1'b1;
        busRequestN = 1'b1;
    end
    always @(posedge clk)
    begin
        cnt <= readStrobeN ? 4'h0 : cnt + 4'h1;
        busReadyN <= cnt >= stallLen;
        busRequestN <= !holdReq;
        busDataIn <= readStrobeN ? ~busDataIn : 16'hA5C3;
    end
endmodule : ebw_far_model

// >>> sim/ebw_bus_ctrl_tb.sv
// Purpose: Self-checking bench of the bus controller
// Assumes: Zero-wait register bus
// Notes:   Strobe lengths counted in clk cycles
`timescale 1ns/1ns
`include "ebw_defines.svh"
module ebw_bus_ctrl_tb
    import ebw_pkg::*;
;
    logic clk, srst, hsel, hwrite, hreadyout, hresp, busClk;
    logic rdN, ctrlOe, ale, readyN, reqN, grantN, holdReq, bad;
    logic wrN, wrlN, wrhN, bheN;
    logic [31:0] haddr, hwdata, hrdata, q, len;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [23:0] busAddr, busAddrOe;
    logic [15:0] busDataOut, busDataOe, busDataIn;
    logic [3:0]  areaSelectN, stallLen;
    ebw_cmd_t    cmd;
    int          errCount, checksDone, cyc, n, i;

    ebw_bus_ctrl dut_u (
        .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .busClk(busClk), .busAddr(busAddr), .busAddrOe(busAddrOe),
        .busDataOut(busDataOut), .busDataOe(busDataOe),
        .busDataIn(busDataIn), .readStrobeN(rdN),
        .writeStrobeN(wrN), .lowByteWriteN(wrlN), .highByteWriteN(wrhN),
        .upperByteEnableN(bheN), .areaSelectN(areaSelectN),
        .ctrlOe(ctrlOe), .addrLatchEnable(ale),
        .busReadyN(readyN), .busRequestN(reqN),
        .busReleaseGrantN(grantN));
    ebw_far_model model_u (
        .clk(clk), .readStrobeN(rdN), .stallLen(stallLen),
        .holdReq(holdReq), .busDataIn(busDataIn),
        .busReadyN(readyN), .busRequestN(reqN));

    // ****
    // Tasks
    // ****
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : ahb
    task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            errCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic rdLen(input logic [2:0] w);
        cmd = '{waitSel: w, write: 1'b0, area: 2'h0, kind: EBW_KIND_EXT};
        ahb(1'b1, `EBW_OFS_CMD, {24'h000000, cmd});
        len = 32'h0;
        n = 0;
        while (rdN !== 1'b0 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        while (rdN === 1'b0 && len < 32'd200)
        begin
            @(negedge clk);
            len++;
        end
    endtask : rdLen
    task automatic end_of_test;
        $display("Checks %0d errors %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    // ****
    // Clock and timeout
    // ****
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errCount++;
            end_of_test;
        end
    end

    // ****
    // Tests
    // ****
    initial
    begin
        {clk, hsel, hwrite, holdReq, bad} = 5'h00;
        {haddr, hwdata, htrans, stallLen} = 70'h0;
        {hsize, srst, errCount, checksDone, cyc} = {3'h2, 1'b1, 96'h0};
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        ahb(1'b0, `EBW_OFS_CTRL, 32'h0);
        cmp(q, 48'h0);
        ahb(1'b0, 8'h40, 32'h0);
        cmp(q, 48'h0);
        for (i = 0; i < 8; i++)
            ahb(1'b1, 8'(4 * i), 32'(i % 4));
        for (i = 0; i < 8; i++)
        begin
            ahb(1'b0, 8'(4 * i), 32'h0);
            cmp(q, 48'(i % 4));
        end
        ahb(1'b1, `EBW_OFS_CTRL, 32'h2);
        for (i = 0; i < 4; i++)
        begin
            rdLen(3'(i));
            cmp(len, 48'(2 * (i + 1)));
        end
        ahb(1'b0, `EBW_OFS_RDATA, 32'h0);
        cmp(q[15:0], 48'hA5C3);
        ahb(1'b1, `EBW_OFS_ADDR, 32'h123456);
        ahb(1'b1, `EBW_OFS_WDATA, 32'hBEEF);
        cmd = '{waitSel: 3'h1, write: 1'b1, area: 2'h2, kind: EBW_KIND_EXT};
        ahb(1'b1, `EBW_OFS_CMD, {24'h000000, cmd});
        wait (areaSelectN === 4'hB);
        @(negedge clk);
        cmp({busAddr, busDataOut, busClk}, {24'h123456, 16'hBEEF, 1'b0});
        cmp({busDataOe, rdN, wrN, wrlN, wrhN, bheN, hresp}, 48'h3FFFE0);
        ahb(1'b1, `EBW_OFS_CTRL, 32'hA);
        for (i = 0; i < 2; i++)
        begin
            rdLen(3'(i));
            cmp(len, 48'h6);
        end
        ahb(1'b1, `EBW_OFS_CTRL, 32'h2);
        stallLen <= 4'h4;
        rdLen(3'h0);
        cmp(len, 48'h2);
        rdLen(3'h1);
        cmp(len > 32'd4, 48'h1);
        for (i = 0; i < 4; i++)
        begin
            ahb(1'b1, `EBW_OFS_CTRL, 32'(2 + i / 2));
            cmd = '{waitSel: 3'h3, write: 1'b0, area: 2'h0,
                    kind: ebw_kind_t'(1 + i % 2)};
            ahb(1'b1, `EBW_OFS_CMD, {24'h000000, cmd});
            repeat (12) @(posedge clk);
            ahb(1'b0, `EBW_OFS_STATUS, 32'h0);
            cmp(q, 48'h10);
        end
        stallLen <= 4'h0;
        ahb(1'b1, `EBW_OFS_CTRL, 32'h0);
        holdReq <= 1'b1;
        repeat (20) @(posedge clk);
        cmp(grantN, 48'h1);
        holdReq <= 1'b0;
        ahb(1'b1, `EBW_OFS_CTRL, 32'h2);
        repeat (10) @(posedge clk);
        fork
            rdLen(3'h3);
            begin
                wait (rdN === 1'b0);
                @(posedge clk);
                holdReq <= 1'b1;
                while (rdN === 1'b0)
                begin
                    @(negedge clk);
                    bad = bad | (grantN !== 1'b1);
                end
            end
        join
        cmp(bad, 48'h0);
        for (n = 0; n < 40 && grantN !== 1'b0; n++)
            @(negedge clk);
        cmp(grantN, 48'h0);
        cmp({busAddrOe, busDataOe, ctrlOe, ale}, 48'h0);
        @(posedge clk);
        holdReq <= 1'b0;
        for (n = 0; n < 40 && grantN !== 1'b1; n++)
            @(negedge clk);
        cmp(grantN, 48'h1);
        repeat (2) @(negedge clk);
        cmp({busAddrOe, ctrlOe}, {23'h0, 25'h1FFFFFF});
        end_of_test;
    end
endmodule : ebw_bus_ctrl_tb
